// >>> rtl/iexmd_map.vh
/*
 Constants of the execution and multiply/divide datapath.
 Assumes inclusion by the design, checker and testbench files.
*/
// What this block does
// - ALU logical, shift, add and subtract in one cycle.
// - Thirty-two 32-bit general registers.
// - Seven shadow register sets, switched without saving.
// - Two read ports, one write port, full bypass.
// - Data address adder; next address unit with branch logic.
// - Leading zero/one count, load and store aligners, trap compare.
// - Multiply/divide pipe runs on while the integer pipeline stalls.
// - Booth 32x32 multiplier; first source operand, then second.
// - Four high/low accumulator pairs.
// - A new multiply accepted every cycle.
// - Multiply: latency five into the accumulators, four for MUL into a register via bypass; repeat one cycle.
// - Divider makes one quotient bit per cycle.
// - Early-in skips 23, 15 or 7 iterations for 8, 16, 24-bit dividends.
// - Divide latency unsigned/signed 12/14, 20/22, 28/30, 36/38 cycles.
// - Multiply/divide op during a divide stalls until it ends.
`ifndef IEXMD_MAP_VH
`define IEXMD_MAP_VH
`define ALU_ADD 4'h0
`define ALU_SUB 4'h1
`define ALU_AND 4'h2
`define ALU_OR 4'h3
`define ALU_XOR 4'h4
`define ALU_NOR 4'h5
`define ALU_SLL 4'h6
`define ALU_SRL 4'h7
`define ALU_SRA 4'h8
`define ALU_SLT 4'h9
`define ALU_SLTU 4'ha
`define ALU_CLZ 4'hb
`define ALU_CLO 4'hc
`define BR_EQ 3'h0
`define BR_NE 3'h1
`define BR_LTZ 3'h2
`define BR_GEZ 3'h3
`define BR_LEZ 3'h4
`define BR_GTZ 3'h5
`define TR_EQ 3'h0
`define TR_NE 3'h1
`define TR_LT 3'h2
`define TR_LTU 3'h3
`define TR_GE 3'h4
`define TR_GEU 3'h5
`define SZ_BYTE 2'h0
`define SZ_HALF 2'h1
`define SZ_WORD 2'h2
`define MD_MULT 4'h0
`define MD_MULTU 4'h1
`define MD_MADD 4'h2
`define MD_MADDU 4'h3
`define MD_MSUB 4'h4
`define MD_MSUBU 4'h5
`define MD_MUL 4'h6
`define MD_DIV 4'h7
`define MD_DIVU 4'h8
`define MD_MFHI 4'h9
`define MD_MFLO 4'ha
`define MD_MTHI 4'hb
`define MD_MTLO 4'hc
`define MUL_LATENCY 5
`define DIV_SKIP8 6'h17
`define DIV_SKIP16 6'h0f
`define DIV_SKIP24 6'h07
`define DIV_LAT8 6'h0c
`define DIV_LAT8S 6'h0e
`define DIV_LAT16 6'h14
`define DIV_LAT16S 6'h16
`define DIV_LAT24 6'h1c
`define DIV_LAT24S 6'h1e
`define DIV_LAT32 6'h24
`define DIV_LAT32S 6'h26
`endif

// >>> rtl/iexmd_divider.v
/*
 Iterative divider: one quotient bit per cycle with early-in skipping.
 Assumes the caller holds off a new start while busy is high.
*/
`timescale 1ns/1ns
`default_nettype none
`include "iexmd_map.vh"
module iexmd_divider (
    input wire ref_clk,
    input wire srst,
    input wire start,
    input wire isSigned,
    input wire [31:0] dividend,
    input wire [31:0] divisor,
    output wire busy,
    output wire done,
    output wire [31:0] quotient,
    output wire [31:0] remainder
);
    reg [5:0] cnt_reg;
    reg [5:0] iter_reg;
    reg [31:0] quo_reg;
    reg [31:0] rem_reg;
    reg [31:0] dvs_reg;
    reg negQ_reg;
    reg negR_reg;
    wire negA = isSigned & dividend[31];
    wire negB = isSigned & divisor[31];
    wire [31:0] magA = negA ? (~dividend + 32'h1) : dividend;
    wire [31:0] magB = negB ? (~divisor + 32'h1) : divisor;
    reg [5:0] skip;
    reg [5:0] lat;
    wire [32:0] part = {rem_reg, quo_reg[31]};
    wire [33:0] diff = {1'b0, part} - {2'h0, dvs_reg};

    // -------------------------------------------
    // Early-in size class
    // -------------------------------------------
    always @*
    begin
        // Judged on the magnitude, so small negative dividends also skip
        if (magA[31:8] == 24'h0)
        begin
            skip = `DIV_SKIP8;
            lat = isSigned ? `DIV_LAT8S : `DIV_LAT8;
        end
        else if (magA[31:16] == 16'h0)
        begin
            skip = `DIV_SKIP16;
            lat = isSigned ? `DIV_LAT16S : `DIV_LAT16;
        end
        else if (magA[31:24] == 8'h0)
        begin
            skip = `DIV_SKIP24;
            lat = isSigned ? `DIV_LAT24S : `DIV_LAT24;
        end
        else
        begin
            skip = 6'h0;
            lat = isSigned ? `DIV_LAT32S : `DIV_LAT32;
        end
    end

    // -------------------------------------------
    // Restoring iteration
    // -------------------------------------------
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            cnt_reg <= 6'h0;
            iter_reg <= 6'h0;
            quo_reg <= 32'h0;
            rem_reg <= 32'h0;
            dvs_reg <= 32'h0;
            negQ_reg <= 1'b0;
            negR_reg <= 1'b0;
        end
        else if (start && !busy)
        begin
            cnt_reg <= lat - 6'h1;
            iter_reg <= 6'h20 - skip;
            quo_reg <= magA << skip;
            rem_reg <= 32'h0;
            dvs_reg <= magB;
            negQ_reg <= negA ^ negB;
            negR_reg <= negA;
        end
        else if (busy)
        begin
            cnt_reg <= cnt_reg - 6'h1;
            if (iter_reg != 6'h0)
            begin
                iter_reg <= iter_reg - 6'h1;
                if (!diff[33])
                begin
                    rem_reg <= diff[31:0];
                    quo_reg <= {quo_reg[30:0], 1'b1};
                end
                else
                begin
                    rem_reg <= part[31:0];
                    quo_reg <= {quo_reg[30:0], 1'b0};
                end
            end
        end
    end

    assign busy = (cnt_reg != 6'h0);
    assign done = (cnt_reg == 6'h1);
    assign quotient = negQ_reg ? (~quo_reg + 32'h1) : quo_reg;
    assign remainder = negR_reg ? (~rem_reg + 32'h1) : rem_reg;
endmodule // iexmd_divider
`default_nettype wire

// >>> rtl/iexmd_exec_unit.v
/*
 Integer execution datapath with shadowed registers and multiply/divide unit.
 Assumes the issue pipeline honours mdStall.
*/
`timescale 1ns/1ns
`default_nettype none
`include "iexmd_map.vh"
module iexmd_exec_unit #(
    parameter SETS = 8
) (
    input wire ref_clk,
    input wire srst,
    input wire pipeStall,
    input wire [2:0] activeSet,
    input wire opValid,
    input wire [3:0] aluOp,
    input wire [4:0] rsIdx,
    input wire [4:0] rtIdx,
    input wire [4:0] rdIdx,
    input wire useImm,
    input wire [31:0] imm,
    input wire [31:0] pc,
    input wire isBranch,
    input wire isJumpReg,
    input wire [2:0] branchCond,
    input wire trapEn,
    input wire [2:0] trapCond,
    input wire [1:0] storeSize,
    input wire [31:0] loadData,
    input wire [1:0] loadSize,
    input wire loadSigned,
    input wire mdValid,
    input wire [3:0] mdOp,
    input wire [1:0] mdAcc,
    output wire mdStall,
    output reg exValid_reg,
    output reg [31:0] exResult_reg,
    output reg [31:0] dataAddr_reg,
    output reg [31:0] storeData_reg,
    output reg [3:0] storeByteEn_reg,
    output reg [31:0] nextPc_reg,
    output reg branchTaken_reg,
    output reg trapHit_reg,
    output reg [31:0] loadAligned_reg,
    output reg mdReadValid_reg,
    output reg [31:0] mdReadData_reg
);
    reg [31:0] regFile [0:SETS*32-1];
    reg [31:0] accHi [0:3];
    reg [31:0] accLo [0:3];
    reg [4:0] aluRd_reg;
    reg [2:0] aluSet_reg;
    reg [3:0] mulOp_reg [1:4];
    reg [1:0] mulAcc_reg [1:4];
    reg [4:0] mulRd_reg [1:4];
    reg [2:0] mulSet_reg [1:4];
    reg [4:1] mulV_reg;
    reg [32:0] mulA_reg;
    reg [32:0] mulB_reg;
    reg [63:0] prod_reg [2:4];
    reg [1:0] divAcc_reg;
    integer k;

    // -------------------------------------------
    // Helper functions for leading count and Booth product
    // -------------------------------------------
    function [5:0] leadZeros;
        input [31:0] v;
        integer i;
        begin
            leadZeros = 6'h20;
            for (i = 0; i < 32; i = i + 1)
                if (v[i])
                    leadZeros = 6'h1f - i[5:0];
        end
    endfunction

    // Radix-4 Booth recoding on 33-bit signed operands
    function [65:0] boothMul;
        input [32:0] a;
        input [32:0] b;
        reg [34:0] m;
        reg [65:0] ae;
        integer i;
        begin
            m = {b[32], b, 1'b0};
            ae = {{33{a[32]}}, a};
            boothMul = 66'h0;
            for (i = 0; i < 17; i = i + 1)
                case (m[2*i+2 -: 3])
                    3'b001, 3'b010: boothMul = boothMul + (ae << (2 * i));
                    3'b011: boothMul = boothMul + (ae << (2 * i + 1));
                    3'b100: boothMul = boothMul - (ae << (2 * i + 1));
                    3'b101, 3'b110: boothMul = boothMul - (ae << (2 * i));
                    default: boothMul = boothMul;
                endcase
        end
    endfunction

    // -------------------------------------------
    // Register file write port and bypass
    // -------------------------------------------
    // A register-destination multiply owns the port in its final cycle
    wire mulRegWb = mulV_reg[4] && mulOp_reg[4] == `MD_MUL;
    wire wbEn = mulRegWb || exValid_reg;
    wire [4:0] wbIdx = mulRegWb ? mulRd_reg[4] : aluRd_reg;
    wire [2:0] wbSet = mulRegWb ? mulSet_reg[4] : aluSet_reg;
    wire [63:0] mulSum;
    wire [31:0] wbData = mulRegWb ? mulSum[31:0] : exResult_reg;
    wire rsHit = wbEn && wbSet == activeSet && wbIdx == rsIdx;
    wire rtHit = wbEn && wbSet == activeSet && wbIdx == rtIdx;
    wire [31:0] rsVal = (rsIdx == 5'h0) ? 32'h0 : rsHit ? wbData :
        regFile[{activeSet, rsIdx}];
    wire [31:0] rtVal = (rtIdx == 5'h0) ? 32'h0 : rtHit ? wbData :
        regFile[{activeSet, rtIdx}];

    always @(posedge ref_clk)
    begin
        if (wbEn && wbIdx != 5'h0)
            regFile[{wbSet, wbIdx}] <= wbData;
    end

    // -------------------------------------------
    // ALU, address, branch and trap logic
    // -------------------------------------------
    wire [31:0] opB = useImm ? imm : rtVal;
    wire [4:0] shAmt = useImm ? imm[4:0] : rsVal[4:0];
    wire [32:0] diffAB = {1'b0, rsVal} - {1'b0, opB};
    wire ltS = (rsVal[31] != opB[31]) ? rsVal[31] : diffAB[31];
    wire ltU = diffAB[32];
    wire [31:0] addr = rsVal + imm;
    wire [31:0] pcSeq = pc + 32'h4;
    wire [31:0] brTarget = pcSeq + {imm[29:0], 2'h0};
    reg [31:0] aluOut;
    reg brCond;
    reg trCond;

    always @*
    begin
        case (aluOp)
            `ALU_ADD: aluOut = rsVal + opB;
            `ALU_SUB: aluOut = diffAB[31:0];
            `ALU_AND: aluOut = rsVal & opB;
            `ALU_OR: aluOut = rsVal | opB;
            `ALU_XOR: aluOut = rsVal ^ opB;
            `ALU_NOR: aluOut = ~(rsVal | opB);
            `ALU_SLL: aluOut = rtVal << shAmt;
            `ALU_SRL: aluOut = rtVal >> shAmt;
            `ALU_SRA: aluOut = $signed(rtVal) >>> shAmt;
            `ALU_SLT: aluOut = {31'h0, ltS};
            `ALU_SLTU: aluOut = {31'h0, ltU};
            `ALU_CLZ: aluOut = {26'h0, leadZeros(rsVal)};
            `ALU_CLO: aluOut = {26'h0, leadZeros(~rsVal)};
            default: aluOut = 32'h0;
        endcase
        case (branchCond)
            `BR_EQ: brCond = (rsVal == rtVal);
            `BR_NE: brCond = (rsVal != rtVal);
            `BR_LTZ: brCond = rsVal[31];
            `BR_GEZ: brCond = !rsVal[31];
            `BR_LEZ: brCond = rsVal[31] || rsVal == 32'h0;
            `BR_GTZ: brCond = !rsVal[31] && rsVal != 32'h0;
            default: brCond = 1'b0;
        endcase
        case (trapCond)
            `TR_EQ: trCond = (rsVal == opB);
            `TR_NE: trCond = (rsVal != opB);
            `TR_LT: trCond = ltS;
            `TR_LTU: trCond = ltU;
            `TR_GE: trCond = !ltS;
            `TR_GEU: trCond = !ltU;
            default: trCond = 1'b0;
        endcase
    end

    // -------------------------------------------
    // Execute stage registers
    // -------------------------------------------
    wire take = opValid && !pipeStall;

    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            exValid_reg <= 1'b0;
            exResult_reg <= 32'h0;
            aluRd_reg <= 5'h0;
            aluSet_reg <= 3'h0;
            dataAddr_reg <= 32'h0;
            storeData_reg <= 32'h0;
            storeByteEn_reg <= 4'h0;
            nextPc_reg <= 32'h0;
            branchTaken_reg <= 1'b0;
            trapHit_reg <= 1'b0;
            loadAligned_reg <= 32'h0;
        end
        else
        begin
            exValid_reg <= take;
            if (take)
            begin
                exResult_reg <= aluOut;
                aluRd_reg <= rdIdx;
                aluSet_reg <= activeSet;
                dataAddr_reg <= addr;
                branchTaken_reg <= isBranch && brCond;
                nextPc_reg <= isJumpReg ? rsVal :
                    (isBranch && brCond) ? brTarget : pcSeq;
                trapHit_reg <= trapEn && trCond;
                // Store aligner: lanes follow the low address bits, little-endian
                case (storeSize)
                    `SZ_BYTE:
                    begin
                        storeData_reg <= {4{rtVal[7:0]}};
                        storeByteEn_reg <= 4'h1 << addr[1:0];
                    end
                    `SZ_HALF:
                    begin
                        storeData_reg <= {2{rtVal[15:0]}};
                        storeByteEn_reg <= addr[1] ? 4'hc : 4'h3;
                    end
                    default:
                    begin
                        storeData_reg <= rtVal;
                        storeByteEn_reg <= 4'hf;
                    end
                endcase
            end
            // Load aligner works on the address of the previous execute
            case (loadSize)
                `SZ_BYTE: loadAligned_reg <= {{24{loadSigned &
                    loadData[{dataAddr_reg[1:0], 3'h7}]}},
                    loadData[{dataAddr_reg[1:0], 3'h0} +: 8]};
                `SZ_HALF: loadAligned_reg <= {{16{loadSigned &
                    loadData[{dataAddr_reg[1], 4'hf}]}},
                    loadData[{dataAddr_reg[1], 4'h0} +: 16]};
                default: loadAligned_reg <= loadData;
            endcase
        end
    end

    // -------------------------------------------
    // Multiply/divide unit
    // -------------------------------------------
    // Runs independent of pipeStall so queued work drains during stalls
    wire divBusy;
    wire divDone;
    wire [31:0] divQuo;
    wire [31:0] divRem;
    assign mdStall = mdValid && divBusy;
    wire mdTake = mdValid && !divBusy;
    wire isMul = mdOp <= `MD_MUL;
    wire isDiv = mdOp == `MD_DIV || mdOp == `MD_DIVU;
    wire mulSigned = !(mdOp == `MD_MULTU || mdOp == `MD_MADDU || mdOp == `MD_MSUBU);
    wire [3:0] fOp = mulOp_reg[4];
    wire [1:0] fAcc = mulAcc_reg[4];
    wire [63:0] accPair = {accHi[fAcc], accLo[fAcc]};
    wire [65:0] prodFull = boothMul(mulA_reg, mulB_reg);
    assign mulSum = (fOp == `MD_MADD || fOp == `MD_MADDU) ? accPair + prod_reg[4] :
        (fOp == `MD_MSUB || fOp == `MD_MSUBU) ? accPair - prod_reg[4] : prod_reg[4];

    iexmd_divider uDiv (
        .ref_clk(ref_clk),
        .srst(srst),
        .start(mdTake && isDiv),
        .isSigned(mdOp == `MD_DIV),
        .dividend(rsVal),
        .divisor(rtVal),
        .busy(divBusy),
        .done(divDone),
        .quotient(divQuo),
        .remainder(divRem)
    );

    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            mulV_reg <= 4'h0;
            divAcc_reg <= 2'h0;
            mdReadValid_reg <= 1'b0;
            mdReadData_reg <= 32'h0;
            for (k = 0; k < 4; k = k + 1)
            begin
                accHi[k] <= 32'h0;
                accLo[k] <= 32'h0;
            end
        end
        else
        begin
            // Five-stage multiply pipe: operands, Booth product, two delays, accumulate
            mulV_reg <= {mulV_reg[3:1], mdTake && isMul};
            mulA_reg <= {mulSigned & rsVal[31], rsVal};
            mulB_reg <= {mulSigned & rtVal[31], rtVal};
            prod_reg[2] <= prodFull[63:0];
            prod_reg[3] <= prod_reg[2];
            prod_reg[4] <= prod_reg[3];
            mulOp_reg[1] <= mdOp;
            mulAcc_reg[1] <= mdAcc;
            mulRd_reg[1] <= rdIdx;
            mulSet_reg[1] <= activeSet;
            for (k = 2; k < 5; k = k + 1)
            begin
                mulOp_reg[k] <= mulOp_reg[k-1];
                mulAcc_reg[k] <= mulAcc_reg[k-1];
                mulRd_reg[k] <= mulRd_reg[k-1];
                mulSet_reg[k] <= mulSet_reg[k-1];
            end
            if (mdTake && isDiv)
                divAcc_reg <= mdAcc;
            mdReadValid_reg <= mdTake && (mdOp == `MD_MFHI || mdOp == `MD_MFLO);
            if (mdTake && mdOp == `MD_MFHI)
                mdReadData_reg <= accHi[mdAcc];
            if (mdTake && mdOp == `MD_MFLO)
                mdReadData_reg <= accLo[mdAcc];
            if (mdTake && mdOp == `MD_MTHI)
                accHi[mdAcc] <= rsVal;
            if (mdTake && mdOp == `MD_MTLO)
                accLo[mdAcc] <= rsVal;
            if (mulV_reg[4] && fOp != `MD_MUL)
            begin
                accHi[fAcc] <= mulSum[63:32];
                accLo[fAcc] <= mulSum[31:0];
            end
            if (divDone)
            begin
                accLo[divAcc_reg] <= divQuo;
                accHi[divAcc_reg] <= divRem;
            end
        end
    end
endmodule // iexmd_exec_unit
`default_nettype wire

// >>> bench/iexmd_checker.sv
/*
 Port checks of the execution unit.
 Assumes mdValid is held until mdStall drops.
*/
`timescale 1ns/1ns
`default_nettype none
`include "iexmd_map.vh"
module iexmd_checker (
    input wire ref_clk,
    input wire srst,
    input wire pipeStall,
    input wire opValid,
    input wire mdValid,
    input wire [3:0] mdOp,
    input wire mdStall,
    input wire exValid_reg,
    input wire [31:0] exResult_reg,
    input wire mdReadValid_reg
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire mdTake = mdValid && !mdStall;
    wire divTake = mdTake && (mdOp == `MD_DIV || mdOp == `MD_DIVU);
    wire mfTake = mdTake && (mdOp == `MD_MFHI || mdOp == `MD_MFLO);
    reg [5:0] stallRun_reg;
    // Length of the current stall run; a divide never stalls past 37
    always @(posedge ref_clk)
    begin
        if (srst || !mdStall)
            stallRun_reg <= 6'h00;
        else
            stallRun_reg <= stallRun_reg + 6'h01;
    end
    a_reset_clear: assert property (@(posedge ref_clk) disable iff (1'b0)
        srst |=> !exValid_reg && !mdReadValid_reg) else $error("reset left a pulse");
    a_stall_cause: assert property (mdStall |-> mdValid)
        else $error("stall without request");
    a_exec_taken: assert property (opValid && !pipeStall |=> exValid_reg)
        else $error("taken op gave no result");
    a_exec_refused: assert property (!(opValid && !pipeStall) |=> !exValid_reg)
        else $error("result without taken op");
    a_result_hold: assert property (!exValid_reg |-> $stable(exResult_reg))
        else $error("result moved without op");
    a_read_answer: assert property (mfTake |=> mdReadValid_reg)
        else $error("accumulator read gave no answer");
    a_read_only: assert property (mdReadValid_reg |-> $past(mfTake))
        else $error("read pulse without read");
    a_mul_repeat: assert property (mdTake && mdOp <= `MD_MUL |=> !mdStall)
        else $error("multiply blocked the next op");
    a_div_stall: assert property (divTake |=> (!mdValid || mdStall)[*8]
        ##1 (!mdValid || mdStall)[*3]) else $error("op taken during divide");
    a_div_bound: assert property (stallRun_reg <= 6'h25)
        else $error("divide stall too long");
endmodule // iexmd_checker
bind iexmd_exec_unit iexmd_checker iexmd_checker_inst (.ref_clk, .srst, .pipeStall, .opValid,
    .mdValid, .mdOp, .mdStall, .exValid_reg, .exResult_reg, .mdReadValid_reg);
`default_nettype wire

// >>> bench/iexmd_issue_model.sv
/*
 Model of the integer issue pipeline.
 Assumes tasks start at a falling edge.
*/
`timescale 1ns/1ns
`default_nettype none
module iexmd_issue_model (
    input wire ref_clk,
    input wire mdStall,
    output reg pipeStall,
    output reg [2:0] activeSet,
    output reg opValid,
    output reg [3:0] aluOp,
    output reg [4:0] rsIdx,
    output reg [4:0] rtIdx,
    output reg [4:0] rdIdx,
    output reg useImm,
    output reg [31:0] imm,
    output reg [31:0] pc,
    output reg isBranch,
    output reg isJumpReg,
    output reg [2:0] branchCond,
    output reg trapEn,
    output reg [2:0] trapCond,
    output reg [1:0] storeSize,
    output reg [31:0] loadData,
    output reg [1:0] loadSize,
    output reg loadSigned,
    output reg mdValid,
    output reg [3:0] mdOp,
    output reg [1:0] mdAcc
);
    initial
    begin
        {pipeStall, activeSet, opValid, aluOp, rsIdx, rtIdx, rdIdx, useImm, imm} = '0;
        {pc, isBranch, isJumpReg, branchCond, trapEn, trapCond, storeSize} = '0;
        {loadData, loadSize, loadSigned, mdValid, mdOp, mdAcc} = '0;
    end
    // Leaves opValid high so ops may follow back to back
    task alu(input [3:0] op, input [4:0] sa, input [4:0] sb, input [4:0] rd, input ui,
        input [31:0] im);
    begin
        {opValid, aluOp, rsIdx, rtIdx, rdIdx, useImm, imm} = {1'b1, op, sa, sb, rd, ui, im};
        @(negedge ref_clk);
    end
    endtask
    task md(input [3:0] op, input [1:0] acc, input [4:0] sa, input [4:0] sb,
        output integer stalls);
    begin
        {mdValid, mdOp, mdAcc, rsIdx, rtIdx} = {1'b1, op, acc, sa, sb};
        stalls = 0;
        #1;
        // Request held unchanged while refused
        while (mdStall !== 1'b0 && stalls < 64)
        begin
            @(negedge ref_clk);
            #1;
            stalls = stalls + 1;
        end
        @(negedge ref_clk);
    end
    endtask
    task idle;
    begin
        {opValid, mdValid} = 2'b00;
        @(negedge ref_clk);
    end
    endtask
endmodule // iexmd_issue_model
`default_nettype wire

// >>> bench/testbench.sv
/*
 Self-checking bench of the execution unit.
 Assumes design, checker and model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "iexmd_map.vh"
module testbench;
    localparam [31:0] OPA = 32'h800000f0;
    reg ref_clk = 1'b0;
    reg srst = 1'b1;
    integer err_total = 0;
    integer n_compared = 0;
    integer st;
    integer i;
    wire pipeStall, opValid, useImm, isBranch, isJumpReg, trapEn, loadSigned, mdValid;
    wire mdStall, exValid_reg, branchTaken_reg, trapHit_reg, mdReadValid_reg;
    wire [1:0] storeSize, loadSize, mdAcc;
    wire [2:0] activeSet, branchCond, trapCond;
    wire [3:0] aluOp, mdOp, storeByteEn_reg;
    wire [4:0] rsIdx, rtIdx, rdIdx;
    wire [31:0] imm, pc, loadData, exResult_reg, dataAddr_reg, storeData_reg;
    wire [31:0] nextPc_reg, loadAligned_reg, mdReadData_reg;
    iexmd_exec_unit iexmd_exec_unit_inst (.*);
    iexmd_issue_model issue (.*);
    initial
    begin
        forever #10 ref_clk = ~ref_clk;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task chk(input [31:0] exp, input [31:0] got, input [127:0] nm);
    begin
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            $display("Error %0s expected %h seen %h", nm, exp, got);
            err_total = err_total + 1;
        end
    end
    endtask
    task alu(input [3:0] op, input [4:0] sa, input [4:0] sb, input [4:0] rd, input ui,
        input [31:0] im);
        issue.alu(op, sa, sb, rd, ui, im);
    endtask
    task md(input [3:0] op, input [1:0] acc, input [4:0] sa, input [4:0] sb);
        issue.md(op, acc, sa, sb, st);
    endtask
    task idle;
        issue.idle();
    endtask
    // Shifts read both operands from one register: amount is OPA[4:0]
    function [31:0] aluRef(input [3:0] op, input [31:0] a, input [31:0] b);
    begin
        case (op)
            `ALU_ADD: aluRef = a + b;
            `ALU_SUB: aluRef = a - b;
            `ALU_AND: aluRef = a & b;
            `ALU_OR: aluRef = a | b;
            `ALU_XOR: aluRef = a ^ b;
            `ALU_NOR: aluRef = ~(a | b);
            `ALU_SLL: aluRef = b << a[4:0];
            `ALU_SRL: aluRef = b >> a[4:0];
            `ALU_SRA: aluRef = $signed(b) >>> a[4:0];
            `ALU_SLT: aluRef = {31'h0, $signed(a) < $signed(b)};
            `ALU_SLTU: aluRef = {31'h0, a < b};
            `ALU_CLZ: aluRef = 32'h0;
            default: aluRef = 32'h1;
        endcase
    end
    endfunction
    task divOne(input [31:0] dvd, input sg, input [31:0] lat);
        reg [31:0] q;
        reg [31:0] r;
    begin
        q = dvd / 32'h7;
        r = dvd % 32'h7;
        if (sg)
        begin
            q = $signed(dvd) / 32'sd7;
            r = $signed(dvd) % 32'sd7;
        end
        alu(`ALU_ADD, 0, 0, 10, 1, dvd);
        idle();
        issue.pipeStall = sg;
        md(sg ? `MD_DIV : `MD_DIVU, 1, 10, 11);
        md(`MD_MFLO, 1, 0, 0);
        chk(lat - 32'h1, st, "div stall");
        chk(q, mdReadData_reg, "quotient");
        md(`MD_MFHI, 1, 0, 0);
        chk(r, mdReadData_reg, "remainder");
        idle();
        issue.pipeStall = 1'b0;
    end
    endtask
    task stop_test;
    begin
        $display("Compared %0d, errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
    begin
        chk(32'h0, {31'h0, exValid_reg}, "exValid");
        md(`MD_MFHI, 3, 0, 0);
        chk(32'h0, mdReadData_reg, "acc after reset");
        idle();
    end
    endtask
    task t_alu;
    begin
        alu(`ALU_ADD, 0, 0, 1, 1, OPA);
        alu(`ALU_ADD, 0, 0, 2, 1, 32'h3);
        // First op reads r2 straight after its write: bypass, no stall
        for (i = 0; i < 13; i = i + 1)
        begin
            alu(i[3:0], 1, (i >= 6 && i <= 8) ? 5'd1 : 5'd2, 3, 0, 32'h0);
            chk(aluRef(i[3:0], OPA, (i >= 6 && i <= 8) ? OPA : 32'h3),
                exResult_reg, "alu");
        end
        idle();
    end
    endtask
    task t_sets;
    begin
        for (i = 0; i < 8; i = i + 1)
        begin
            issue.activeSet = i[2:0];
            alu(`ALU_ADD, 0, 0, 31, 1, 32'h11 * i + 32'h1);
        end
        for (i = 7; i >= 0; i = i - 1)
        begin
            issue.activeSet = i[2:0];
            alu(`ALU_ADD, 31, 0, 4, 1, 32'h0);
            chk(32'h11 * i + 32'h1, exResult_reg, "shadow reg");
        end
        idle();
    end
    endtask
    task t_mem;
    begin
        {issue.storeSize, issue.loadSize} = 4'ha;
        {issue.trapEn, issue.trapCond} = {1'b1, `TR_NE};
        {issue.isBranch, issue.branchCond} = {1'b1, `BR_NE};
        issue.isJumpReg = 1'b1;
        alu(`ALU_ADD, 1, 2, 5, 1, 32'h10);
        chk(OPA + 32'h10, dataAddr_reg, "data addr");
        chk(OPA, nextPc_reg, "next pc");
        chk(32'h3, storeData_reg, "store data");
        chk(32'hf, {28'h0, storeByteEn_reg}, "byte enables");
        chk(32'h1, {31'h0, trapHit_reg}, "trap");
        chk(32'h1, {31'h0, branchTaken_reg}, "branch");
        issue.loadData = 32'hc0ffee11;
        issue.pipeStall = 1'b1;
        alu(`ALU_ADD, 0, 0, 6, 1, 32'h55);
        chk(32'hc0ffee11, loadAligned_reg, "load aligned");
        chk(32'h0, {31'h0, exValid_reg}, "stalled op");
        chk(OPA + 32'h10, exResult_reg, "held result");
        {issue.trapEn, issue.isJumpReg, issue.isBranch} = 3'h0;
        idle();
        issue.pipeStall = 1'b0;
    end
    endtask
    task t_mul;
    begin
        md(`MD_MULTU, 0, 1, 2);
        md(`MD_MULT, 1, 1, 2);
        md(`MD_MULTU, 2, 1, 2);
        md(`MD_MADD, 2, 1, 2);
        chk(32'h0, st, "mul stall");
        idle();
        md(`MD_MFLO, 0, 0, 0);
        chk(32'h800002d0, mdReadData_reg, "multu lo");
        md(`MD_MFHI, 1, 0, 0);
        chk(32'hfffffffe, mdReadData_reg, "mult hi");
        idle();
        md(`MD_MFLO, 2, 0, 0);
        chk(32'h5a0, mdReadData_reg, "madd lo");
        md(`MD_MFHI, 2, 0, 0);
        chk(32'h0, mdReadData_reg, "madd hi");
        idle();
    end
    endtask
    initial
    begin
        #100000;
        err_total = err_total + 1;
        stop_test();
    end
    initial
    begin
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        srst = 1'b0;
        t_reset();
        t_alu();
        t_sets();
        t_mem();
        t_mul();
        alu(`ALU_ADD, 0, 0, 11, 1, 32'h7);
        idle();
        divOne(32'h64, 1'b0, 32'd12);
        divOne(32'h1234, 1'b0, 32'd20);
        divOne(32'h123456, 1'b0, 32'd28);
        divOne(32'h12345678, 1'b0, 32'd36);
        divOne(32'hffffff9c, 1'b1, 32'd14);
        stop_test();
    end
endmodule // testbench
`default_nettype wire
